// ===== rtl/ddl_pkg.sv
// Package with constants shared by the dual channel serial write latch.
package ddl_pkg;
    localparam int          DDL_WORD_BITS    = 16;
    localparam int          DDL_CODE_BITS    = 12;
    localparam int          DDL_SEL_POS      = 15;
    localparam int          DDL_GAIN_POS     = 13;
    localparam int          DDL_ACTIVE_POS   = 12;
    localparam int          DDL_CODE_MSB     = 11;
    localparam logic [4:0]  DDL_FULL_COUNT   = 5'h10;
    localparam logic        DDL_GAIN_RST     = 1'b0;
    localparam logic        DDL_ACTIVE_RST   = 1'b0;
    localparam logic [11:0] DDL_CODE_RST     = 12'h000;
    localparam int          DDL_SYNC_STAGES  = 3;
endpackage

// ===== rtl/ddl_pin_sync.sv
// Three stage pin synchroniser; a change counts once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module ddl_pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             mclk_i,
    input  wire logic             rst_n_i,
    // Pins, reset levels and filtered levels.
    input  wire logic [WIDTH-1:0] pin_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output var  logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] level_next;
    logic             armed_reg;

    initial begin
        if (WIDTH < 1) begin
            $error("ddl_pin_sync: WIDTH must be at least one");
        end
    end

    // Where the last two stages disagree the previous level is held.
    assign level_next = (s2_reg == s3_reg) ? s3_reg : level_o;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_reg    <= '0;
            s2_reg    <= '0;
            s3_reg    <= '0;
            level_o   <= '0;
            armed_reg <= 1'b0;
        end else begin
            s1_reg    <= pin_i;
            s2_reg    <= s1_reg;
            s3_reg    <= s2_reg;
            armed_reg <= 1'b1;
            level_o   <= armed_reg ? level_next : rst_val_i;
        end
    end
endmodule
`default_nettype wire

// ===== rtl/ddl_top.sv
// Serial write and double buffered latch logic of a dual channel converter.
//
// Summary of operation
// - Code is unsigned straight binary.
// - Gain bit one means unity, zero double.
// - Gain defaults to double after reset.
// - Active bit one runs channel, zero shuts down.
// - Bit 15 picks channel B; bit 14 ignored.
// - Code from bits 11..0; low bits per variant.
// - Data sampled on rising serial clock edge.
// - No readback path exists.
// - Command is one 16-bit word.
// - Clocks after the sixteenth are ignored.
// - Fewer than 16 clocks discards the word.
// - Nothing shifts while select is high.
// - Select rising loads addressed input register.
// - Low strobe copies both inputs to outputs.
// - Channels stay shut down until written.
// - Undervoltage resets; stays reset until new write.
// - Shutdown per channel; receiver keeps working.
// - Channel wakes only when active bit latched.
// - Select is active low.
// - Tied-low strobe updates at select rising.
`timescale 1ns/1ns
`default_nettype none
module ddl_top #(
    parameter int RESOLUTION = ddl_pkg::DDL_CODE_BITS
) (
    // Clock and reset.
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    // Serial link pins.
    input  wire logic        chip_select_n_i,
    input  wire logic        serial_clock_i,
    input  wire logic        serial_data_i,
    // Latch strobe and supply monitor.
    input  wire logic        output_latch_strobe_n_i,
    input  wire logic        supply_low_i,
    // Channel A output register.
    output var  logic [11:0] output_a_code_o,
    output var  logic        output_a_gain_select_n_o,
    output var  logic        output_a_channel_active_o,
    // Channel B output register.
    output var  logic [11:0] output_b_code_o,
    output var  logic        output_b_gain_select_n_o,
    output var  logic        output_b_channel_active_o,
    // Input register contents and load pulse, for observation.
    output var  logic [11:0] input_a_code_o,
    output var  logic [11:0] input_b_code_o,
    output var  logic        load_pulse_o
);
    import ddl_pkg::*;

    typedef enum logic [2:0] {
        DDL_IDLE  = 3'b001,
        DDL_SHIFT = 3'b010,
        DDL_FULL  = 3'b100
    } ddl_state_t;

    typedef struct packed {
        logic        gain_n;
        logic        active;
        logic [11:0] code;
    } ddl_chan_t;

    localparam int NCH = 2;

    initial begin
        if (RESOLUTION != 8 && RESOLUTION != 10 && RESOLUTION != 12) begin
            $error("ddl_top: RESOLUTION must be 8, 10 or 12");
        end
    end

    // Reset release synchroniser; the supply monitor stays separate and drives only the channel reset.
    logic rst_s1_reg;
    logic rst_n_reg;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1_reg <= 1'b0;
            rst_n_reg  <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n_reg  <= rst_s1_reg;
        end
    end

    // Pin synchronisation: select, clock, data, strobe, supply monitor.
    logic [4:0] pins_raw;
    logic [4:0] pins_lvl;
    logic       cs_n;
    logic       sck;
    logic       sdi;
    logic       strobe_n;
    logic       supply_low;

    // Active-low pins pass inverted so that every idle level matches the all-zero
    // reset state of the synchroniser and no false select edge follows reset.
    assign pins_raw = {supply_low_i, ~output_latch_strobe_n_i, serial_data_i, serial_clock_i, ~chip_select_n_i};

    ddl_pin_sync #(
        .WIDTH (5)
    ) u_sync (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_reg),
        .pin_i     (pins_raw),
        .rst_val_i (5'h00),
        .level_o   (pins_lvl)
    );

    assign cs_n       = ~pins_lvl[0];
    assign sck        = pins_lvl[1];
    assign sdi        = pins_lvl[2];
    assign strobe_n   = ~pins_lvl[3];
    assign supply_low = pins_lvl[4];

    // Edge detection on the filtered levels.
    logic sck_d_reg;
    logic cs_n_d_reg;
    logic sck_rise;
    logic cs_fall;
    logic cs_rise;

    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            sck_d_reg  <= 1'b0;
            cs_n_d_reg <= 1'b1;
        end else begin
            sck_d_reg  <= sck;
            cs_n_d_reg <= cs_n;
        end
    end

    assign sck_rise = sck & ~sck_d_reg;
    assign cs_fall  = ~cs_n & cs_n_d_reg;
    assign cs_rise  = cs_n & ~cs_n_d_reg;

    // Receiver state machine.
    ddl_state_t         state_reg;
    ddl_state_t         state_next;
    logic [15:0]        shift_reg;
    logic [15:0]        shift_next;
    logic [4:0]         count_reg;
    logic [4:0]         count_next;
    logic               take_bit;
    logic               word_done;

    // Shifting stops once sixteen bits are in, and never runs with select high.
    assign take_bit  = sck_rise & ~cs_n & (state_reg == DDL_SHIFT);
    assign word_done = cs_rise & (state_reg == DDL_FULL);

    always_comb begin
        state_next = state_reg;
        shift_next = shift_reg;
        count_next = count_reg;
        case (state_reg)
            DDL_IDLE: begin
                if (cs_fall) begin
                    state_next = DDL_SHIFT;
                    count_next = 5'h00;
                end
            end
            DDL_SHIFT: begin
                if (cs_n) begin
                    state_next = DDL_IDLE;
                end else if (take_bit) begin
                    shift_next = {shift_reg[14:0], sdi};
                    count_next = count_reg + 5'h01;
                    if (count_reg + 5'h01 == DDL_FULL_COUNT) begin
                        state_next = DDL_FULL;
                    end
                end
            end
            DDL_FULL: begin
                if (cs_n) begin
                    state_next = DDL_IDLE;
                end
            end
            default: begin
                state_next = DDL_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            state_reg <= DDL_IDLE;
            shift_reg <= 16'h0000;
            count_reg <= 5'h00;
        end else begin
            state_reg <= state_next;
            shift_reg <= shift_next;
            count_reg <= count_next;
        end
    end

    // Command decode from the completed word.
    function automatic logic [11:0] ddl_mask_code(input logic [11:0] raw);
        logic [11:0] m;
        m = 12'hFFF;
        if (RESOLUTION == 10) begin
            m = 12'hFFC;
        end else if (RESOLUTION == 8) begin
            m = 12'hFF0;
        end
        return raw & m;
    endfunction

    logic      cmd_sel_b;
    ddl_chan_t cmd_word;

    assign cmd_sel_b       = shift_reg[DDL_SEL_POS];
    assign cmd_word.gain_n = shift_reg[DDL_GAIN_POS];
    assign cmd_word.active = shift_reg[DDL_ACTIVE_POS];
    assign cmd_word.code   = ddl_mask_code(shift_reg[DDL_CODE_MSB:0]);

    // Input and output registers per channel, in a generate loop.
    ddl_chan_t in_reg  [NCH];
    ddl_chan_t out_reg [NCH];
    logic      load_pulse_reg;
    logic      chan_rst;
    logic      strobe_low;
    logic      written_reg;

    // Undervoltage holds both channels in reset.
    assign chan_rst   = supply_low;
    assign strobe_low = ~strobe_n;

    // After reset or undervoltage, no transfer until a fresh valid write.
    always_ff @(posedge mclk_i or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            written_reg    <= 1'b0;
            load_pulse_reg <= 1'b0;
        end else begin
            load_pulse_reg <= word_done & ~chan_rst;
            if (chan_rst) begin
                written_reg <= 1'b0;
            end else if (word_done) begin
                written_reg <= 1'b1;
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            logic      hit;
            ddl_chan_t rst_val;

            assign hit     = word_done & (cmd_sel_b == (ch == 1)) & ~chan_rst;
            assign rst_val = '{gain_n: DDL_GAIN_RST, active: DDL_ACTIVE_RST, code: DDL_CODE_RST};

            always_ff @(posedge mclk_i or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    in_reg[ch] <= '{gain_n: DDL_GAIN_RST, active: DDL_ACTIVE_RST, code: DDL_CODE_RST};
                end else if (chan_rst) begin
                    in_reg[ch] <= rst_val;
                end else if (hit) begin
                    in_reg[ch] <= cmd_word;
                end
            end

            // Level-sensitive transfer, both channels together; a strobe held
            // low passes a new word one cycle after it reaches the input register.
            always_ff @(posedge mclk_i or negedge rst_n_reg) begin
                if (!rst_n_reg) begin
                    out_reg[ch] <= '{gain_n: DDL_GAIN_RST, active: DDL_ACTIVE_RST, code: DDL_CODE_RST};
                end else if (chan_rst) begin
                    out_reg[ch] <= rst_val;
                end else if (strobe_low && written_reg) begin
                    out_reg[ch] <= in_reg[ch];
                end
            end
        end
    endgenerate

    // Outputs straight from registers; there is no path back to the link.
    assign output_a_code_o           = out_reg[0].code;
    assign output_a_gain_select_n_o  = out_reg[0].gain_n;
    assign output_a_channel_active_o = out_reg[0].active;
    assign output_b_code_o           = out_reg[1].code;
    assign output_b_gain_select_n_o  = out_reg[1].gain_n;
    assign output_b_channel_active_o = out_reg[1].active;
    assign input_a_code_o            = in_reg[0].code;
    assign input_b_code_o            = in_reg[1].code;
    assign load_pulse_o              = load_pulse_reg;
endmodule
`default_nettype wire

// ===== verif/ddl_top_sva.sv
// Port-level assertions for the dual channel serial write latch.
`timescale 1ns/1ns
`default_nettype none
module ddl_top_sva #(
    parameter int RESOLUTION = 12
) (
    // Clock, reset and pins.
    input wire logic        mclk_i,
    input wire logic        resetn_i,
    input wire logic        chip_select_n_i,
    input wire logic        output_latch_strobe_n_i,
    input wire logic        supply_low_i,
    // Registers.
    input wire logic [11:0] output_a_code_o,
    input wire logic        output_a_channel_active_o,
    input wire logic [11:0] output_b_code_o,
    input wire logic        output_b_channel_active_o,
    input wire logic [11:0] input_a_code_o,
    input wire logic [11:0] input_b_code_o,
    input wire logic        load_pulse_o
);
    localparam logic [11:0] LOW_MASK = 12'((1 << (12 - RESOLUTION)) - 1);
    // Counts consecutive cycles with select high, saturating.
    logic [3:0] cs_hi_cnt;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cs_hi_cnt <= 4'h0;
        end else if (!chip_select_n_i) begin
            cs_hi_cnt <= 4'h0;
        end else if (cs_hi_cnt != 4'hF) begin
            cs_hi_cnt <= cs_hi_cnt + 4'h1;
        end
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    a_pulse_spacing: assert property (load_pulse_o |=> !load_pulse_o [*8])
        else $error("load pulses too close");
    a_select_idle: assert property (chip_select_n_i && cs_hi_cnt >= 4'hB |-> !load_pulse_o)
        else $error("load while select idle");
    a_load_a_pulse: assert property ($changed(input_a_code_o) && input_a_code_o != 12'h000 |-> load_pulse_o)
        else $error("input A changed without load");
    a_load_b_pulse: assert property ($changed(input_b_code_o) && input_b_code_o != 12'h000 |-> load_pulse_o)
        else $error("input B changed without load");
    a_low_bits: assert property (((input_a_code_o | input_b_code_o | output_a_code_o) & LOW_MASK) == 12'h000)
        else $error("unused code bits set");
    a_strobe_hold: assert property ((output_latch_strobe_n_i && !supply_low_i) [*8] |->
        $stable(output_a_code_o) && $stable(output_b_code_o))
        else $error("output moved with strobe high");
    a_strobe_track: assert property (!output_latch_strobe_n_i [*8] ##0 load_pulse_o |->
        ##1 output_a_code_o == input_a_code_o && output_b_code_o == input_b_code_o)
        else $error("output did not follow input");
    a_undervolt_off: assert property (supply_low_i [*8] |-> !output_a_channel_active_o &&
        !output_b_channel_active_o && input_a_code_o == 12'h000)
        else $error("channel alive in undervoltage");
    c_track: cover property (!output_latch_strobe_n_i && load_pulse_o);
    c_undervolt: cover property (supply_low_i [*8]);
    c_wake: cover property ($rose(output_b_channel_active_o));
endmodule
bind ddl_top ddl_top_sva #(.RESOLUTION(RESOLUTION)) u_sva (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .chip_select_n_i(chip_select_n_i),
    .output_latch_strobe_n_i(output_latch_strobe_n_i), .supply_low_i(supply_low_i),
    .output_a_code_o(output_a_code_o), .output_a_channel_active_o(output_a_channel_active_o),
    .output_b_code_o(output_b_code_o), .output_b_channel_active_o(output_b_channel_active_o),
    .input_a_code_o(input_a_code_o), .input_b_code_o(input_b_code_o), .load_pulse_o(load_pulse_o)
);
`default_nettype wire

// ===== verif/ddl_spi_host.sv
// Behavioural serial host that shifts command words into the latch block.
`timescale 1ns/1ns
`default_nettype none
module ddl_spi_host (
    // Serial link pins.
    output var logic chip_select_n_o,
    output var logic serial_clock_o,
    output var logic serial_data_o
);
    initial begin
        chip_select_n_o = 1'b1;
        serial_clock_o  = 1'b0;
        serial_data_o   = 1'b0;
    end
    // Clocks past the sixteenth carry the inverse of bit 0 so that using them shows.
    task automatic send(input logic [15:0] w, input int nclk, input logic idle_hi, input logic cs_hi);
        serial_clock_o  = idle_hi;
        chip_select_n_o = cs_hi;
        #80;
        for (int i = 0; i < nclk; i++) begin
            serial_clock_o = 1'b0;
            serial_data_o  = (i < 16) ? w[15 - i] : ~w[0];
            #80;
            serial_clock_o = 1'b1;
            #80;
        end
        serial_clock_o  = idle_hi;
        chip_select_n_o = 1'b1;
        serial_data_o   = ~serial_data_o;
    endtask
endmodule
`default_nettype wire

// ===== verif/ddl_top_tb.sv
// Self-checking bench for the dual channel serial write latch.
`timescale 1ns/1ns
`default_nettype none
module ddl_top_tb;
    logic        mclk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        chip_select_n_i, serial_clock_i, serial_data_i;
    logic        output_latch_strobe_n_i = 1'b1;
    logic        supply_low_i = 1'b0;
    logic [11:0] oac, obc, iac, ibc;
    logic        oag, oaa, obg, oba, lp;
    logic [13:0] out_a, out_b, in_a, in_b;
    int          bad_count = 0;
    int          check_count = 0;
    int          lp_count = 0;
    always @(posedge mclk_i) begin
        if (lp === 1'b1) begin
            lp_count++;
        end
    end
    assign out_a = {oag, oaa, oac};
    assign out_b = {obg, oba, obc};
    assign in_a  = {2'b00, iac};
    assign in_b  = {2'b00, ibc};
    always #5 mclk_i = ~mclk_i;
    ddl_spi_host u_host (.chip_select_n_o(chip_select_n_i), .serial_clock_o(serial_clock_i),
        .serial_data_o(serial_data_i));
    ddl_top #(.RESOLUTION(10)) dut (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .chip_select_n_i(chip_select_n_i), .serial_clock_i(serial_clock_i), .serial_data_i(serial_data_i),
        .output_latch_strobe_n_i(output_latch_strobe_n_i), .supply_low_i(supply_low_i),
        .output_a_code_o(oac), .output_a_gain_select_n_o(oag), .output_a_channel_active_o(oaa),
        .output_b_code_o(obc), .output_b_gain_select_n_o(obg), .output_b_channel_active_o(oba),
        .input_a_code_o(iac), .input_b_code_o(ibc), .load_pulse_o(lp));
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (12) @(posedge mclk_i);
        #1;
    endtask
    task automatic tx(input logic [15:0] w, input int n, input logic m11, input logic hi);
        @(posedge mclk_i);
        #1;
        u_host.send(w, n, m11, hi);
        settle();
    endtask
    task automatic t_reset();
        chk(out_a, 14'h0000);
        chk(out_b, 14'h0000);
    endtask
    task automatic t_double_buffer();
        tx(16'h3ABF, 16, 1'b0, 1'b0);
        tx(16'hA5A7, 16, 1'b1, 1'b0);
        chk(in_a, 14'h0ABC);
        chk(in_b, 14'h05A4);
        chk(out_a, 14'h0000);
        output_latch_strobe_n_i = 1'b0;
        settle();
        chk(out_a, 14'h3ABC);
        chk(out_b, 14'h25A4);
    endtask
    task automatic t_frame_length();
        tx(16'h0FFF, 15, 1'b0, 1'b0);
        chk(out_a, 14'h3ABC);
        tx(16'h1123, 20, 1'b1, 1'b0);
        chk(out_a, 14'h1120);
    endtask
    task automatic t_select_high();
        tx(16'h8000, 16, 1'b0, 1'b1);
        chk(out_b, 14'h25A4);
    endtask
    task automatic t_undervolt();
        supply_low_i = 1'b1;
        repeat (20) @(posedge mclk_i);
        chk(out_a, 14'h0000);
        tx(16'h3111, 16, 1'b0, 1'b0);
        chk(in_a, 14'h0000);
        supply_low_i = 1'b0;
        settle();
        chk(out_b, 14'h0000);
        tx(16'h9FFF, 16, 1'b0, 1'b0);
        chk(out_b, 14'h1FFC);
        chk(out_a, 14'h0000);
        chk(lp_count[13:0], 14'h0004);
    endtask
    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge mclk_i);
        #1 resetn_i = 1'b1;
        settle();
        t_reset();
        t_double_buffer();
        t_frame_length();
        t_select_high();
        t_undervolt();
        results();
    end
    initial begin
        #200000;
        bad_count++;
        results();
    end
endmodule
`default_nettype wire
